/* File: hdl/dagc_map.vh */
// Control word indices, field positions, encodings and reset values for the AGC.
// Assumes a control word write port carrying a word index and 32-bit data.
`ifndef DAGC_MAP_VH
`define DAGC_MAP_VH

// Control word indices
`define DAGC_CW_LOOP 8'h08
`define DAGC_CW_LIMIT 8'h09
`define DAGC_CW_BERST 8'h19
`define DAGC_CW_MODE 8'h1B

// Threshold and loop gain word fields
`define DAGC_THR_HI 28
`define DAGC_THR_LO 16
`define DAGC_LG0_MAN_HI 3
`define DAGC_LG0_MAN_LO 0
`define DAGC_LG0_EXP_HI 7
`define DAGC_LG0_EXP_LO 4
`define DAGC_LG1_MAN_HI 11
`define DAGC_LG1_MAN_LO 8
`define DAGC_LG1_EXP_HI 15
`define DAGC_LG1_EXP_LO 12

// Gain limit word fields
`define DAGC_UPR_HI 27
`define DAGC_UPR_LO 16
`define DAGC_LWR_HI 11
`define DAGC_LWR_LO 0

// Mode word bits
`define DAGC_PRESERVE_BIT 15
`define DAGC_MEDIAN_BIT 16

// Widths
`define DAGC_IN_W 26
`define DAGC_OUT_W 16
`define DAGC_THR_W 13
`define DAGC_ERR_W 14
`define DAGC_ACC_W 28
`define DAGC_LIM_W 12

// Median mode fixed errors, sign extended to the error width
`define DAGC_MED_POS 14'h0200
`define DAGC_MED_NEG 14'h3E00

// Loop gain exponent complement base, accumulator shift alignment
`define DAGC_LG_EXP_BASE 4'hF
`define DAGC_ERR_ALIGN 8

// Accumulator layout: exponent, mantissa, fine fraction
`define DAGC_ACC_EXP_HI 27
`define DAGC_ACC_EXP_LO 24
`define DAGC_ACC_MAN_HI 23
`define DAGC_ACC_MAN_LO 9
`define DAGC_ACC_LIM_LO 16

// Reset values
`define DAGC_CW_RST 32'h0000_0000
`define DAGC_ACC_RST 28'h000_0000

`endif

/* File: hdl/dagc_scale.v */
// Gain multiplier/shifter for one sample path, with overflow saturation.
// Assumes gain exponent and mantissa stay steady while the sample is presented.
`include "dagc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dagc_scale (
   input wire signed [25:0] smp_i,
   input wire [3:0] exp_i,
   input wire [14:0] man_i,
   output reg [15:0] out_o,
   output reg sat_o
);
   wire signed [16:0] mult;
   wire signed [42:0] prod;
   wire signed [57:0] shifted;
   wire signed [42:0] scaled;
   wire ovf;
   // Gain is 2^N times (1 + X * 2^-15)
   assign mult = $signed({2'b01, man_i});
   assign prod = smp_i * mult;
   assign shifted = $signed({{15{prod[42]}}, prod}) <<< exp_i;
   assign scaled = shifted[57:15];
   // Any sign spill above the 26-bit word is overflow
   assign ovf = (scaled[42:25] != {18{scaled[25]}});
   always @* begin
      sat_o = ovf;
      if (ovf) begin
         out_o = scaled[42] ? 16'h8000 : 16'h7FFF;
      end else begin
         out_o = scaled[25:10];
      end
   end
endmodule // dagc_scale
`default_nettype wire

/* File: hdl/dagc_buf2.v */
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; ready and valid outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module dagc_buf2 #(
   parameter W = 34
) (
   input wire ref_clk_i,
   input wire rst_i,
   input wire [W-1:0] wr_data_i,
   input wire wr_valid_i,
   output reg wr_ready_o,
   output reg [W-1:0] rd_data_o,
   output reg rd_valid_o,
   input wire rd_ready_i
);
   reg [W-1:0] mem_r [0:1];
   reg wptr_r;
   reg rptr_r;
   reg [1:0] cnt_r;
   reg [1:0] cnt_nxt;
   wire push;
   wire pop;
   assign push = wr_valid_i & wr_ready_o;
   assign pop = rd_valid_o & rd_ready_i;
   always @* begin
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = cnt_r + 2'd1;
      end else if (pop & ~push) begin
         cnt_nxt = cnt_r - 2'd1;
      end
   end
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
         cnt_r <= 2'd0;
         wr_ready_o <= 1'b1;
         rd_valid_o <= 1'b0;
         mem_r[0] <= {W{1'b0}};
         mem_r[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_r[wptr_r] <= wr_data_i;
            wptr_r <= ~wptr_r;
         end
         if (pop) begin
            rptr_r <= ~rptr_r;
         end
         cnt_r <= cnt_nxt;
         wr_ready_o <= (cnt_nxt != 2'd2);
         rd_valid_o <= (cnt_nxt != 2'd0);
      end
   end
   always @* begin
      rd_data_o = mem_r[rptr_r];
   end
endmodule // dagc_buf2
`default_nettype wire

/* File: hdl/dagc_top.v */
// Digital AGC: I/Q gain multiplier/shifter with saturation and its gain loop.
// Assumes control words arrive on a write strobe, magnitudes from the converter downstream.
`include "dagc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dagc_top (
   input wire ref_clk_i,
   input wire rst_i,
   input wire [7:0] cw_index_i,
   input wire [31:0] cw_data_i,
   input wire cw_write_i,
   input wire sync_input_two_i,
   input wire loop_gain_select_pin_i,
   input wire [25:0] fir_i_i,
   input wire [25:0] fir_q_i,
   input wire fir_valid_i,
   output wire fir_ready_o,
   output wire [15:0] out_i_o,
   output wire [15:0] out_q_o,
   output wire sat_i_o,
   output wire sat_q_o,
   output wire out_valid_o,
   input wire out_ready_i,
   input wire [12:0] magnitude_i,
   input wire magnitude_valid_i,
   output reg [11:0] gain_level_o,
   output reg backend_reset_o
);
   // Control words
   reg [31:0] loop_word_r;
   reg [31:0] limit_word_r;
   reg [31:0] mode_word_r;
   reg berst_r;

   // Field views
   wire [12:0] magnitude_threshold;
   wire [3:0] loop_gain_mantissa;
   wire [3:0] loop_gain_exponent;
   wire [11:0] upper_limit;
   wire [11:0] lower_limit;
   wire median_mode;
   wire preserve;

   // Loop datapath
   reg [27:0] acc_r;
   reg [27:0] acc_nxt;
   reg signed [13:0] err;
   reg signed [13:0] err_used;
   reg signed [18:0] err_prod;
   reg signed [27:0] err_wide;
   reg signed [27:0] err_scaled;
   reg [3:0] lg_shift;
   reg signed [28:0] acc_sum;
   reg [27:0] acc_pos;
   wire [11:0] acc_lim_view;
   wire berst_req;

   // Gain stage
   wire [3:0] gain_exp;
   wire [14:0] gain_man;
   wire [15:0] sc_i;
   wire [15:0] sc_q;
   wire sc_sat_i;
   wire sc_sat_q;
   wire [33:0] buf_in;
   wire [33:0] buf_out;

   // Control word writes
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         loop_word_r <= `DAGC_CW_RST;
         limit_word_r <= `DAGC_CW_RST;
         mode_word_r <= `DAGC_CW_RST;
         berst_r <= 1'b0;
      end else begin
         berst_r <= 1'b0;
         if (cw_write_i) begin
            case (cw_index_i)
               `DAGC_CW_LOOP: begin
                  loop_word_r <= cw_data_i;
               end
               `DAGC_CW_LIMIT: begin
                  limit_word_r <= cw_data_i;
               end
               `DAGC_CW_MODE: begin
                  mode_word_r <= cw_data_i;
               end
               `DAGC_CW_BERST: begin
                  berst_r <= 1'b1;
               end
               default: begin
                  berst_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Threshold field with its top bit forced to zero
   assign magnitude_threshold = {1'b0,
      loop_word_r[`DAGC_THR_HI-1:`DAGC_THR_LO]};

   // Loop gain pair chosen by the select pin
   assign loop_gain_mantissa = loop_gain_select_pin_i ?
      loop_word_r[`DAGC_LG1_MAN_HI:`DAGC_LG1_MAN_LO] :
      loop_word_r[`DAGC_LG0_MAN_HI:`DAGC_LG0_MAN_LO];
   assign loop_gain_exponent = loop_gain_select_pin_i ?
      loop_word_r[`DAGC_LG1_EXP_HI:`DAGC_LG1_EXP_LO] :
      loop_word_r[`DAGC_LG0_EXP_HI:`DAGC_LG0_EXP_LO];

   // Gain limits, exponent over mantissa
   assign upper_limit = limit_word_r[`DAGC_UPR_HI:`DAGC_UPR_LO];
   assign lower_limit = limit_word_r[`DAGC_LWR_HI:`DAGC_LWR_LO];

   assign median_mode = mode_word_r[`DAGC_MEDIAN_BIT];
   assign preserve = mode_word_r[`DAGC_PRESERVE_BIT];

   assign berst_req = berst_r | sync_input_two_i;
   assign acc_lim_view = acc_r[`DAGC_ACC_EXP_HI:`DAGC_ACC_LIM_LO];

   // Error detector and scaler
   always @* begin
      // Magnitude arrives already carrying the converter gain
      err = $signed({1'b0, magnitude_threshold}) -
         $signed({1'b0, magnitude_i});
      if (median_mode) begin
         err_used = err[13] ? $signed(`DAGC_MED_NEG) :
            $signed(`DAGC_MED_POS);
      end else begin
         err_used = err;
      end
      err_prod = err_used * $signed({1'b0, loop_gain_mantissa});
      err_wide = $signed({{1{err_prod[18]}}, err_prod, 8'h00});
      lg_shift = `DAGC_LG_EXP_BASE - loop_gain_exponent;
      err_scaled = err_wide >>> lg_shift;
   end

   // Loop filter: accumulate then clamp to the limits
   always @* begin
      acc_sum = $signed({1'b0, acc_r}) + $signed({err_scaled[27], err_scaled});
      if (acc_sum[28]) begin
         acc_pos = 28'h000_0000;
      end else begin
         acc_pos = acc_sum[27:0];
      end
      acc_nxt = acc_pos;
      if (acc_pos[`DAGC_ACC_EXP_HI:`DAGC_ACC_LIM_LO] > upper_limit) begin
         acc_nxt = {upper_limit, 16'h0000};
      end else if (acc_pos[`DAGC_ACC_EXP_HI:`DAGC_ACC_LIM_LO] < lower_limit) begin
         acc_nxt = {lower_limit, 16'h0000};
      end
   end

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_r <= `DAGC_ACC_RST;
         gain_level_o <= 12'h000;
         backend_reset_o <= 1'b0;
      end else begin
         backend_reset_o <= berst_req;
         if (berst_req & ~preserve) begin
            acc_r <= `DAGC_ACC_RST;
         end else if (magnitude_valid_i) begin
            acc_r <= acc_nxt;
         end
         gain_level_o <= acc_lim_view;
      end
   end

   // Gain applied from the accumulator at the moment a sample is taken
   assign gain_exp = acc_r[`DAGC_ACC_EXP_HI:`DAGC_ACC_EXP_LO];
   assign gain_man = acc_r[`DAGC_ACC_MAN_HI:`DAGC_ACC_MAN_LO];

   dagc_scale u_scale_i (
      .smp_i(fir_i_i),
      .exp_i(gain_exp),
      .man_i(gain_man),
      .out_o(sc_i),
      .sat_o(sc_sat_i)
   );

   dagc_scale u_scale_q (
      .smp_i(fir_q_i),
      .exp_i(gain_exp),
      .man_i(gain_man),
      .out_o(sc_q),
      .sat_o(sc_sat_q)
   );

   // Scaled samples land in the buffer on the cycle they are taken
   assign buf_in = {sc_sat_q, sc_sat_i, sc_q, sc_i};

   dagc_buf2 #(
      .W(34)
   ) u_buf (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_data_i(buf_in),
      .wr_valid_i(fir_valid_i),
      .wr_ready_o(fir_ready_o),
      .rd_data_o(buf_out),
      .rd_valid_o(out_valid_o),
      .rd_ready_i(out_ready_i)
   );

   assign out_i_o = buf_out[15:0];
   assign out_q_o = buf_out[31:16];
   assign sat_i_o = buf_out[32];
   assign sat_q_o = buf_out[33];
endmodule // dagc_top
`default_nettype wire

/* File: dv/dagc_sink.sv */
// Downstream sink model for the AGC output stream.
// Assumes one clock; ready is throttled by the bench stall input.
`timescale 1ns/1ps
`default_nettype none
module dagc_sink (
   input wire logic ref_clk_i,
   input wire logic stall_i,
   input wire logic [15:0] out_i_i,
   input wire logic [15:0] out_q_i,
   input wire logic sat_i_i,
   input wire logic sat_q_i,
   input wire logic out_valid_i,
   output logic out_ready_o
);
   logic [33:0] got[$];
   assign out_ready_o = !stall_i;
   always @(posedge ref_clk_i) begin
      if (out_valid_i && out_ready_o) begin
         got.push_back({sat_i_i, sat_q_i, out_i_i, out_q_i});
      end
   end
endmodule // dagc_sink
`default_nettype wire

/* File: dv/dagc_top_asserts.sv */
// Checker on the AGC top ports.
// Assumes bind into dagc_top; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dagc_top_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] cw_index_i,
   input wire logic [31:0] cw_data_i,
   input wire logic cw_write_i,
   input wire logic sync_input_two_i,
   input wire logic fir_valid_i,
   input wire logic fir_ready_o,
   input wire logic [15:0] out_i_o,
   input wire logic [15:0] out_q_o,
   input wire logic sat_i_o,
   input wire logic sat_q_o,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic magnitude_valid_i,
   input wire logic [11:0] gain_level_o,
   input wire logic backend_reset_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   a_out_hold: assert property (out_valid_o && !out_ready_i
      |=> out_valid_o && $stable({out_i_o, out_q_o, sat_i_o, sat_q_o})) else $error("stall lost");
   a_take_valid: assert property (fir_valid_i && fir_ready_o |=> out_valid_o)
      else $error("no valid");
   a_ready_drain: assert property (out_valid_o && out_ready_i |=> fir_ready_o)
      else $error("no ready");
   a_sat_i_code: assert property (sat_i_o && out_valid_o
      |-> out_i_o == 16'h7FFF || out_i_o == 16'h8000) else $error("bad clamp i");
   a_sat_q_code: assert property (sat_q_o && out_valid_o
      |-> out_q_o == 16'h7FFF || out_q_o == 16'h8000) else $error("bad clamp q");
   a_sync_copy: assert property (sync_input_two_i |=> backend_reset_o)
      else $error("no reset copy");
   a_berst_word: assert property (cw_write_i && cw_index_i == 8'h19 |-> ##2 backend_reset_o)
      else $error("no reset word");
   a_gain_hold: assert property (!magnitude_valid_i && !sync_input_two_i && !cw_write_i
      && !backend_reset_o && !$past(backend_reset_o) && !$past(cw_write_i)
      && !$past(sync_input_two_i) |-> ##2 $stable(gain_level_o)) else $error("gain moved");
   a_limit_clamp: assert property ((cw_write_i && cw_index_i == 8'h09
      && cw_data_i[27:16] == cw_data_i[11:0]) ##2 (magnitude_valid_i && !sync_input_two_i
      && !backend_reset_o && !$past(backend_reset_o))
      |-> ##2 gain_level_o == $past(cw_data_i[11:0], 4)) else $error("clamp wrong");
endmodule // dagc_top_asserts
bind dagc_top dagc_top_asserts u_chk (.ref_clk_i, .rst_i, .cw_index_i, .cw_data_i,
   .cw_write_i, .sync_input_two_i, .fir_valid_i, .fir_ready_o, .out_i_o, .out_q_o, .sat_i_o,
   .sat_q_o, .out_valid_o, .out_ready_i, .magnitude_valid_i, .gain_level_o, .backend_reset_o);
`default_nettype wire

/* File: dv/test_dagc_top.sv */
// Self-checking bench for the AGC: control words, sample stream, gain loop.
// Assumes dagc_top, dagc_sink and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module test_dagc_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] idx = 8'h00;
   logic [31:0] data = 32'h0000_0000;
   logic wr = 1'b0, sync = 1'b0, gsel = 1'b0, fv = 1'b0, mv = 1'b0, stall = 1'b0;
   logic [25:0] fi = 26'h000_0000, fq = 26'h000_0000;
   logic [12:0] mag = 13'h0000;
   wire logic fr, ov, ordy, si, sq, bro;
   wire logic [15:0] oi, oq;
   wire logic [11:0] gl;
   int n_fail = 0, n_checks = 0, cyc = 0;
   dagc_top dut (.ref_clk_i(ref_clk), .rst_i(rst), .cw_index_i(idx), .cw_data_i(data),
      .cw_write_i(wr), .sync_input_two_i(sync), .loop_gain_select_pin_i(gsel), .fir_i_i(fi),
      .fir_q_i(fq), .fir_valid_i(fv), .fir_ready_o(fr), .out_i_o(oi), .out_q_o(oq),
      .sat_i_o(si), .sat_q_o(sq), .out_valid_o(ov), .out_ready_i(ordy), .magnitude_i(mag),
      .magnitude_valid_i(mv), .gain_level_o(gl), .backend_reset_o(bro));
   dagc_sink sink (.ref_clk_i(ref_clk), .stall_i(stall), .out_i_i(oi), .out_q_i(oq),
      .sat_i_i(si), .sat_q_i(sq), .out_valid_i(ov), .out_ready_o(ordy));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_smp(input logic [33:0] e);
      int k = 0;
      while (sink.got.size() == 0 && k < 50) begin
         @(posedge ref_clk);
         k++;
      end
      if (sink.got.size() == 0) begin
         chk({34{1'bx}}, e);
      end else begin
         chk(sink.got.pop_front(), e);
      end
   endtask
   task automatic cw(input logic [7:0] i, input logic [31:0] d);
      @(posedge ref_clk);
      idx <= i;
      data <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic pmag(input logic [12:0] m, input logic g);
      @(posedge ref_clk);
      mag <= m;
      gsel <= g;
      mv <= 1'b1;
      @(posedge ref_clk);
      mv <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic send(input logic [25:0] a, input logic [25:0] b);
      @(posedge ref_clk);
      fi <= a;
      fq <= b;
      fv <= 1'b1;
      do @(posedge ref_clk); while (fr !== 1'b1);
      fv <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk(34'({gl, fr, ov}), 34'h2);
      send(26'h012_3400, 26'h3FF_FC00);
      chk_smp(34'h0_048D_FFFF);
      cw(8'h09, 32'h0201_0201);
      pmag(13'h0000, 1'b0);
      chk(34'(gl), 34'h201);
      send(26'h000_8000, 26'h3FF_8000);
      chk_smp(34'h0_0080_FF7F);
      send(26'h100_0000, 26'h000_8000);
      chk_smp(34'h2_7FFF_0080);
      send(26'h000_8000, 26'h300_0000);
      chk_smp(34'h1_0080_8000);
      stall <= 1'b1;
      send(26'h000_8000, 26'h000_0000);
      send(26'h001_0000, 26'h000_0000);
      repeat (2) @(posedge ref_clk);
      chk(34'(fr), 34'h0);
      stall <= 1'b0;
      send(26'h001_8000, 26'h000_0000);
      chk_smp(34'h0_0080_0000);
      chk_smp(34'h0_0101_0000);
      chk_smp(34'h0_0181_0000);
      cw(8'h09, 32'h0FFF_0000);
      cw(8'h19, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      chk(34'(gl), 34'h000);
      cw(8'h08, 32'h1400_F8F0);
      pmag(13'h0000, 1'b0);
      chk(34'(gl), 34'h000);
      pmag(13'h0000, 1'b1);
      chk(34'(gl), 34'h020);
      cw(8'h07, 32'hFFFF_FFFF);
      pmag(13'h0000, 1'b1);
      chk(34'(gl), 34'h040);
      cw(8'h1B, 32'h0001_0000);
      pmag(13'h0800, 1'b1);
      chk(34'(gl), 34'h030);
      pmag(13'h0000, 1'b1);
      chk(34'(gl), 34'h040);
      for (int p = 1; p >= 0; p--) begin
         cw(8'h1B, p ? 32'h0000_8000 : 32'h0000_0000);
         @(posedge ref_clk);
         sync <= 1'b1;
         @(posedge ref_clk);
         sync <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk(34'(gl), p ? 34'h040 : 34'h000);
      end
      final_report();
   end
endmodule // test_dagc_top
`default_nettype wire
